// ==== src/clock_config_map.svh ====
// Purpose: Register offsets, field positions and reset values of the clock block
// Assumes: Byte addresses on a 32-bit AHB-Lite data bus
// Notes: Definitions only
`ifndef CLOCK_CONFIG_MAP_SVH
`define CLOCK_CONFIG_MAP_SVH

`define OFF_FAST_PLL 4'h0
`define OFF_SLOW_SEL 4'h4
`define OFF_AUD_SET0 4'h8
`define OFF_AUD_SET1 4'hc
`define ADDR_LSB 2
`define ADDR_MSB 11
`define HSIZE_WORD 3'h2

`define F_RST 31
`define F_DIV_HI 30
`define F_DIV_LO 28
`define F_SEL_HI 27
`define F_SEL_LO 26
`define F_EN 25
`define F_SYNC 24
`define F_SSEL_HI 25
`define F_SSEL_LO 24
`define F_N_HI 23
`define F_N_LO 16
`define F_M1_HI 15
`define F_M1_LO 8
`define F_M2_HI 3
`define F_M2_LO 0

`define RST_RUN 1'b1
`define RST_DIV 3'h3
`define RST_FAST_SEL 2'h3
`define RST_EN 1'b0
`define RST_SYNC 1'b0
`define RST_FAST_N 8'h03
`define RST_FAST_M1 8'h07
`define RST_FAST_M2 4'h0
`define RST_SLOW_SEL 2'h0
`define RST_AUD0_N 8'h2e
`define RST_AUD0_M1 8'h24
`define RST_AUD1_N 8'h2e
`define RST_AUD1_M1 8'h32
`define RST_AUD_M2 4'h5

`define SRC_PLL 2'h0
`define SRC_REF 2'h1
`define SRC_HALF 2'h2
`define SRC_PIN 2'h3
`define DIV3_LAST 2'h2
`define DIV4_LAST 2'h3
`define STALL_LIMIT 4'hf

`endif

// ==== src/clock_config_pkg.sv ====
// Purpose: Shared types of the clock block
// Assumes: Nothing
// Notes: Numbers live in clock_config_map.svh
package clock_config_pkg;
    typedef logic [1:0] sel_type;
    typedef logic [7:0] coeff_type;
    typedef logic [3:0] post_type;
    typedef logic [2:0] div_type;
endpackage

// ==== src/io_clock_gen_pll_control.sv ====
// Purpose: Clock generation control with AHB-Lite register access
// Assumes: hclk is the system reference; analog PLLs sit outside this module
// Notes: Derived clocks are one-cycle tick enables; pin levels toggle per tick, except clk_io_o, which copies the synchronised fast PLL input
// Behaviour
// - Make six internal and five external clocks, incl. reference and half-rate pairs
// - Fast clock source from bits 27:26: PLL, ref, ref/2, pin; reset 11
// - Slow clock source from bits 25:24: fast/2, ref/2, ref/3, ref/4; reset 00
// - Network, graphics references and printer use the slow clock
// - Audio reference from audio PLL, rate switchable while running
// - Fast PLL disabled: fixed clock pin is an input and fast reference
// - Fast PLL enabled: fixed clock pin drives fast PLL output out
// - Four registers read/write; writes word-only, reads of any size answered
// - Coefficients stored minus one; out = ref*(n+1)/((m1+1)*(m2+1))
// - Fast register: n at 23:16, pre-divisor 15:8, post-divisor 3:0
// - Bit 31 active-low PLL reset default 1; bits 30:28 divisor default 3
// - Enable bit 25 default 0; clear bypasses PLL giving ref/(m2+1)
// - Sync enable bit 24 default 0 selects free run or synchronous
// - Fast coefficients reset to n 3, pre-divisor 7, post-divisor 0
// - Audio control byte mirrors fast control positions, meanings, defaults
// - Audio post-divisor from second audio register bits 3:0, default 5
// - Audio rate select 0 uses first n/pre-divisor pair, 1 second
// - Audio sets reset to n 46/pre 36 and n 46/pre 50
// - Registers decoded at offsets 000, 004, 008, 00C
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "clock_config_map.svh"

module io_clock_gen_pll_control (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic fast_pll_clk_in,
    input wire logic audio_pll_clk_in,
    input wire logic audio_rate_sel,
    input wire logic clk_io_i,
    output logic clk_io_o,
    output logic clk_io_oe,
    output logic fast_pll_reset_n,
    output clock_config_pkg::div_type fast_pll_div,
    output logic fast_pll_enable,
    output logic fast_pll_sync,
    output clock_config_pkg::coeff_type fast_pll_n,
    output clock_config_pkg::coeff_type fast_pll_pre_divisor_field,
    output clock_config_pkg::post_type fast_pll_post_divisor_field,
    output logic audio_pll_reset_n,
    output clock_config_pkg::div_type audio_pll_div,
    output logic audio_pll_enable,
    output logic audio_pll_sync,
    output clock_config_pkg::coeff_type audio_pll_n,
    output clock_config_pkg::coeff_type audio_pll_pre_divisor_field,
    output clock_config_pkg::post_type audio_pll_post_divisor_field,
    output logic sys_clk_en,
    output logic bus_clk,
    output logic bus_clk_n,
    output logic fast_tick,
    output logic slow_tick,
    output logic printer_tick,
    output logic clk_lan,
    output logic clk_gfx,
    output logic clk_flp,
    output logic clk_aud
);
    import clock_config_pkg::*;

    // Register fields
    logic fast_rst_reg;
    div_type fast_div_reg;
    sel_type fast_sel_reg;
    logic fast_en_reg;
    logic fast_sync_reg;
    coeff_type fast_n_reg;
    coeff_type fast_m1_reg;
    post_type fast_m2_reg;
    sel_type slow_sel_reg;
    logic aud_rst_reg;
    div_type aud_div_reg;
    logic aud_en_reg;
    logic aud_sync_reg;
    coeff_type aud0_n_reg;
    coeff_type aud0_m1_reg;
    coeff_type aud1_n_reg;
    coeff_type aud1_m1_reg;
    post_type aud_m2_reg;

    // Bus phase
    logic wr_pend_reg;
    logic [3:0] wr_off_reg;
    logic [31:0] rdata_reg;
    logic addr_ok;
    logic [3:0] addr_off;

    function automatic logic [3:0] offset_of(input logic [31:0] a);
        offset_of = {a[3:`ADDR_LSB], 2'h0};
    endfunction

    function automatic logic mapped(input logic [31:0] a);
        mapped = (a[`ADDR_MSB:4] == '0) && (a[1:0] == 2'h0);
    endfunction

    assign addr_off = offset_of(haddr);
    assign addr_ok = hsel && hready && htrans[1] && mapped(haddr);

    // Zero-wait slave; every answer is OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;

    // Sub-word writes are dropped: register writes are word-only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_off_reg <= 4'h0;
        end else if (hready) begin
            wr_pend_reg <= addr_ok && hwrite && (hsize == `HSIZE_WORD);
            wr_off_reg <= addr_off;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= 32'h0;
        end else if (hready) begin
            rdata_reg <= 32'h0;
            if (addr_ok && !hwrite) begin
                case (addr_off)
                    `OFF_FAST_PLL: begin
                        rdata_reg <= {fast_rst_reg, fast_div_reg, fast_sel_reg, fast_en_reg,
                            fast_sync_reg, fast_n_reg, fast_m1_reg, 4'h0, fast_m2_reg};
                    end
                    `OFF_SLOW_SEL: begin
                        rdata_reg <= {6'h0, slow_sel_reg, 24'h0};
                    end
                    `OFF_AUD_SET0: begin
                        rdata_reg <= {aud_rst_reg, aud_div_reg, 2'h0, aud_en_reg,
                            aud_sync_reg, aud0_n_reg, aud0_m1_reg, 8'h0};
                    end
                    `OFF_AUD_SET1: begin
                        rdata_reg <= {8'h0, aud1_n_reg, aud1_m1_reg, 4'h0, aud_m2_reg};
                    end
                    default: begin
                        rdata_reg <= 32'h0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_rst_reg <= `RST_RUN;
            fast_div_reg <= `RST_DIV;
            fast_sel_reg <= `RST_FAST_SEL;
            fast_en_reg <= `RST_EN;
            fast_sync_reg <= `RST_SYNC;
            fast_n_reg <= `RST_FAST_N;
            fast_m1_reg <= `RST_FAST_M1;
            fast_m2_reg <= `RST_FAST_M2;
        end else if (wr_pend_reg && wr_off_reg == `OFF_FAST_PLL) begin
            fast_rst_reg <= hwdata[`F_RST];
            fast_div_reg <= hwdata[`F_DIV_HI:`F_DIV_LO];
            fast_sel_reg <= hwdata[`F_SEL_HI:`F_SEL_LO];
            fast_en_reg <= hwdata[`F_EN];
            fast_sync_reg <= hwdata[`F_SYNC];
            fast_n_reg <= hwdata[`F_N_HI:`F_N_LO];
            fast_m1_reg <= hwdata[`F_M1_HI:`F_M1_LO];
            fast_m2_reg <= hwdata[`F_M2_HI:`F_M2_LO];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_sel_reg <= `RST_SLOW_SEL;
        end else if (wr_pend_reg && wr_off_reg == `OFF_SLOW_SEL) begin
            slow_sel_reg <= hwdata[`F_SSEL_HI:`F_SSEL_LO];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aud_rst_reg <= `RST_RUN;
            aud_div_reg <= `RST_DIV;
            aud_en_reg <= `RST_EN;
            aud_sync_reg <= `RST_SYNC;
            aud0_n_reg <= `RST_AUD0_N;
            aud0_m1_reg <= `RST_AUD0_M1;
        end else if (wr_pend_reg && wr_off_reg == `OFF_AUD_SET0) begin
            aud_rst_reg <= hwdata[`F_RST];
            aud_div_reg <= hwdata[`F_DIV_HI:`F_DIV_LO];
            aud_en_reg <= hwdata[`F_EN];
            aud_sync_reg <= hwdata[`F_SYNC];
            aud0_n_reg <= hwdata[`F_N_HI:`F_N_LO];
            aud0_m1_reg <= hwdata[`F_M1_HI:`F_M1_LO];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aud1_n_reg <= `RST_AUD1_N;
            aud1_m1_reg <= `RST_AUD1_M1;
            aud_m2_reg <= `RST_AUD_M2;
        end else if (wr_pend_reg && wr_off_reg == `OFF_AUD_SET1) begin
            aud1_n_reg <= hwdata[`F_N_HI:`F_N_LO];
            aud1_m1_reg <= hwdata[`F_M1_HI:`F_M1_LO];
            aud_m2_reg <= hwdata[`F_M2_HI:`F_M2_LO];
        end
    end

    // Fast PLL controls go straight out of the register flops
    assign fast_pll_reset_n = fast_rst_reg;
    assign fast_pll_div = fast_div_reg;
    assign fast_pll_enable = fast_en_reg;
    assign fast_pll_sync = fast_sync_reg;
    assign fast_pll_n = fast_n_reg;
    assign fast_pll_pre_divisor_field = fast_m1_reg;
    assign fast_pll_post_divisor_field = fast_m2_reg;
    assign audio_pll_reset_n = aud_rst_reg;
    assign audio_pll_div = aud_div_reg;
    assign audio_pll_enable = aud_en_reg;
    assign audio_pll_sync = aud_sync_reg;
    assign audio_pll_post_divisor_field = aud_m2_reg;

    // Three-stage synchronisers for pins and PLL clocks
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] sync_in;
    logic [NSYNC-1:0] s1_reg;
    logic [NSYNC-1:0] s2_reg;
    logic [NSYNC-1:0] s3_reg;
    logic [NSYNC-1:0] stable_reg;
    logic [NSYNC-1:0] rise;

    assign sync_in = {audio_rate_sel, clk_io_i, audio_pll_clk_in, fast_pll_clk_in};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= sync_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    stable_reg[i] <= 1'b0;
                end else if (s2_reg[i] == s3_reg[i]) begin
                    stable_reg[i] <= s3_reg[i];
                end
            end
            assign rise[i] = (s2_reg[i] == s3_reg[i]) && s3_reg[i] && !stable_reg[i];
        end
    endgenerate

    // Reference dividers
    logic half_reg;
    logic [1:0] cnt3_reg;
    logic [1:0] cnt4_reg;
    logic half_tick;
    logic third_tick;
    logic quarter_tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            half_reg <= 1'b0;
            cnt3_reg <= 2'h0;
            cnt4_reg <= 2'h0;
        end else begin
            half_reg <= !half_reg;
            cnt3_reg <= (cnt3_reg == `DIV3_LAST) ? 2'h0 : cnt3_reg + 2'h1;
            cnt4_reg <= cnt4_reg + 2'h1;
        end
    end

    assign half_tick = half_reg;
    assign third_tick = (cnt3_reg == `DIV3_LAST);
    assign quarter_tick = (cnt4_reg == `DIV4_LAST);

    // Bypass dividers give ref/(m2+1) while a PLL is not enabled
    logic [3:0] fbyp_reg;
    logic [3:0] abyp_reg;
    logic fbyp_tick;
    logic abyp_tick;

    assign fbyp_tick = (fbyp_reg >= fast_m2_reg);
    assign abyp_tick = (abyp_reg >= aud_m2_reg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fbyp_reg <= 4'h0;
            abyp_reg <= 4'h0;
        end else begin
            fbyp_reg <= fbyp_tick ? 4'h0 : fbyp_reg + 4'h1;
            abyp_reg <= abyp_tick ? 4'h0 : abyp_reg + 4'h1;
        end
    end

    logic fast_pll_tick;
    logic pin_tick;
    logic slow_half_reg;
    logic [1:0] mux_out;
    logic [3:0] src [2];
    sel_type want [2];

    // An enabled PLL held in reset gives no ticks; the bypass divider ignores reset
    assign fast_pll_tick = fast_en_reg ? (rise[0] && fast_rst_reg) : fbyp_tick;
    // Pin counts as an input only while the PLL is off
    assign pin_tick = fast_en_reg ? fast_pll_tick : rise[2];

    assign src[0] = {pin_tick, half_tick, 1'b1, fast_pll_tick};
    assign src[1] = {quarter_tick, third_tick, half_tick,
        mux_out[0] && slow_half_reg};
    assign want[0] = fast_sel_reg;
    assign want[1] = slow_sel_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_half_reg <= 1'b0;
        end else if (mux_out[0]) begin
            slow_half_reg <= !slow_half_reg;
        end
    end

    // Switch only right after an old tick, then drop the first new tick,
    // so no gap is shorter than either source; a dead source times out.
    generate
        for (genvar g = 0; g < 2; g++) begin : g_mux
            sel_type cur_reg;
            logic hold_reg;
            logic [3:0] stall_reg;
            logic old_tick;
            assign old_tick = src[g][cur_reg];
            assign mux_out[g] = old_tick && !hold_reg;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cur_reg <= (g == 0) ? `RST_FAST_SEL : `RST_SLOW_SEL;
                    hold_reg <= 1'b0;
                    stall_reg <= 4'h0;
                end else if (cur_reg != want[g] &&
                        (old_tick || stall_reg == `STALL_LIMIT)) begin
                    cur_reg <= want[g];
                    hold_reg <= 1'b1;
                    stall_reg <= 4'h0;
                end else begin
                    if (old_tick) begin
                        hold_reg <= 1'b0;
                    end
                    stall_reg <= old_tick ? 4'h0 :
                        (stall_reg == `STALL_LIMIT ? stall_reg : stall_reg + 4'h1);
                end
            end
        end
    endgenerate

    assign fast_tick = mux_out[0];
    assign slow_tick = mux_out[1];
    assign printer_tick = mux_out[1];

    // Audio coefficient set follows the rate select, swapped on an output tick while the audio PLL is enabled, on any cycle while it is not
    logic aud_sel_reg;
    coeff_type aud_n_reg;
    coeff_type aud_m1_reg;
    logic aud_tick;

    assign aud_tick = aud_en_reg ? (rise[1] && aud_rst_reg) : abyp_tick;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aud_sel_reg <= 1'b0;
        end else if (aud_tick || !aud_en_reg) begin
            aud_sel_reg <= stable_reg[3];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aud_n_reg <= `RST_AUD0_N;
            aud_m1_reg <= `RST_AUD0_M1;
        end else begin
            aud_n_reg <= aud_sel_reg ? aud1_n_reg : aud0_n_reg;
            aud_m1_reg <= aud_sel_reg ? aud1_m1_reg : aud0_m1_reg;
        end
    end

    assign audio_pll_n = aud_n_reg;
    assign audio_pll_pre_divisor_field = aud_m1_reg;

    // External and internal clock levels
    logic bus_reg;
    logic flp_reg;
    logic lan_reg;
    logic aud_lvl_reg;
    logic io_reg;
    logic run_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_reg <= 1'b0;
            bus_reg <= 1'b0;
            flp_reg <= 1'b0;
        end else begin
            run_reg <= 1'b1;
            bus_reg <= !bus_reg;
            flp_reg <= !flp_reg;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lan_reg <= 1'b0;
            aud_lvl_reg <= 1'b0;
            io_reg <= 1'b0;
        end else begin
            if (mux_out[1]) begin
                lan_reg <= !lan_reg;
            end
            if (aud_tick) begin
                aud_lvl_reg <= !aud_lvl_reg;
            end
            io_reg <= stable_reg[0];
        end
    end

    assign sys_clk_en = run_reg;
    assign bus_clk = bus_reg;
    assign bus_clk_n = !bus_reg;
    assign clk_flp = flp_reg;
    assign clk_lan = lan_reg;
    assign clk_gfx = lan_reg;
    assign clk_aud = aud_lvl_reg;
    assign clk_io_o = io_reg;
    assign clk_io_oe = fast_en_reg;

endmodule // io_clock_gen_pll_control

// ==== sim/audio_side_model.sv ====
// Purpose: Audio interface and analog clock sources around the clock block
// Assumes: Analog PLL outputs are free-running behavioural clocks
// Notes: The fixed clock pin is resolved here from the block's output enable
`timescale 1ns/10ps

module audio_side_model (
    input wire logic hclk,
    input wire logic rate_req,
    input wire logic clk_io_oe,
    input wire logic clk_io_o,
    output logic fast_pll_clk_in,
    output logic audio_pll_clk_in,
    output logic audio_rate_sel,
    output logic clk_io_i
);
    logic pin_src;

    initial begin
        fast_pll_clk_in = 1'b0;
        audio_pll_clk_in = 1'b0;
        pin_src = 1'b0;
        audio_rate_sel = 1'b0;
    end

    // Periods unrelated to hclk so the synchronisers see every phase
    always #7 fast_pll_clk_in = !fast_pll_clk_in;
    always #11 audio_pll_clk_in = !audio_pll_clk_in;
    always #13 pin_src = !pin_src;

    // Rate select changes only as a level from the audio interface
    always_ff @(posedge hclk) begin
        audio_rate_sel <= rate_req;
    end

    // External oscillator drives the pin only while the block does not
    assign clk_io_i = clk_io_oe ? clk_io_o : pin_src;
endmodule // audio_side_model

// ==== sim/io_clock_gen_pll_control_asserts.sv ====
// Purpose: Concurrent checks on the clock block's ports
// Assumes: Bound to every instance of the clock block
// Notes: Source selects are not ports, so their effect is judged by the bench
`timescale 1ns/10ps

module io_clock_gen_pll_control_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic clk_io_oe,
    input wire logic fast_pll_reset_n,
    input wire clock_config_pkg::div_type fast_pll_div,
    input wire logic fast_pll_enable,
    input wire logic fast_pll_sync,
    input wire clock_config_pkg::coeff_type fast_pll_n,
    input wire clock_config_pkg::coeff_type fast_pll_pre_divisor_field,
    input wire clock_config_pkg::post_type fast_pll_post_divisor_field,
    input wire clock_config_pkg::post_type audio_pll_post_divisor_field,
    input wire logic sys_clk_en,
    input wire logic slow_tick,
    input wire logic printer_tick,
    input wire logic clk_lan,
    input wire logic clk_gfx
);
    import clock_config_pkg::*;

    logic word_req;

    assign word_req = hsel && hready && htrans[1] && hsize == 3'h2;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    chk_oe_on: assert property (fast_pll_enable [*2] |-> clk_io_oe)
        else $error("pin not driven while fast pll enabled");
    chk_oe_off: assert property (!fast_pll_enable [*2] |-> !clk_io_oe)
        else $error("pin driven while fast pll disabled");
    chk_sys_en: assert property ($past(hresetn) |-> sys_clk_en)
        else $error("processor clock enable dropped");
    chk_printer_slow: assert property (printer_tick == slow_tick)
        else $error("printer tick differs from slow tick");
    chk_lan_toggle: assert property (slow_tick |=> clk_lan != $past(clk_lan) && clk_gfx == clk_lan)
        else $error("reference outputs missed a slow tick");
    chk_lan_hold: assert property (!slow_tick |=> $stable(clk_lan))
        else $error("reference output moved without slow tick");
    chk_fast_write: assert property ((word_req && hwrite && haddr[11:0] == 12'h000) ##1 1 |=>
        fast_pll_n == $past(hwdata[23:16]) && fast_pll_enable == $past(hwdata[25])
        && fast_pll_post_divisor_field == $past(hwdata[3:0]))
        else $error("fast pll fields not taken from write data");
    chk_fast_read: assert property ((word_req && !hwrite && haddr[11:0] == 12'h000) |=>
        hrdata[31:28] == {$past(fast_pll_reset_n), $past(fast_pll_div)}
        && hrdata[25:0] == {$past(fast_pll_enable), $past(fast_pll_sync), $past(fast_pll_n),
        $past(fast_pll_pre_divisor_field), 4'h0, $past(fast_pll_post_divisor_field)})
        else $error("fast pll read data wrong");
    chk_aud1_read: assert property ((word_req && !hwrite && haddr[11:0] == 12'h00c) |=>
        hrdata[31:24] == 8'h00 && hrdata[7:0] == {4'h0, $past(audio_pll_post_divisor_field)})
        else $error("audio set one read data wrong");
endmodule // io_clock_gen_pll_control_asserts

bind io_clock_gen_pll_control io_clock_gen_pll_control_asserts chk (.*);

// ==== sim/io_clock_gen_pll_control_tb.sv ====
// Purpose: Self-checking bench for the clock block
// Assumes: Single master on AHB-Lite, hready taken from the slave
// Notes: Tick rates are counted over spans that hold whole periods
`timescale 1ns/10ps

module io_clock_gen_pll_control_tb;
    import clock_config_pkg::*;

    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic fast_pll_clk_in, audio_pll_clk_in, audio_rate_sel, clk_io_i, clk_io_o, clk_io_oe;
    logic fast_pll_reset_n, fast_pll_enable, fast_pll_sync;
    logic audio_pll_reset_n, audio_pll_enable, audio_pll_sync;
    div_type fast_pll_div, audio_pll_div;
    coeff_type fast_pll_n, fast_pll_pre_divisor_field, audio_pll_n, audio_pll_pre_divisor_field;
    post_type fast_pll_post_divisor_field, audio_pll_post_divisor_field;
    logic sys_clk_en, fast_tick, slow_tick, printer_tick, clk_lan, clk_gfx, clk_flp, clk_aud;
    logic bus_clk, bus_clk_n, rate_req;
    int fail_count = 0;
    int checked = 0;

    io_clock_gen_pll_control dut (.bus_clk(bus_clk), .bus_clk_n(bus_clk_n), .*);
    audio_side_model peer (.*);

    assign hready = hreadyout;
    always #10 hclk = !hclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Address phase held until hready, then data phase until hready again
    task automatic bus(input logic [31:0] a, input logic w, input logic [2:0] sz,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        htrans <= 2'h2;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        r = hrdata;
        if (n >= 100) fail_count++;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, 3'h2, d, r);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(a, 1'b0, 3'h2, 32'h0, r);
        chk(r, exp);
    endtask

    task automatic count_ticks(input logic pick_slow, input int span, output int n);
        n = 0;
        repeat (span) begin
            @(negedge hclk);
            if ((pick_slow ? slow_tick : fast_tick) === 1'b1) n++;
        end
        @(posedge hclk);
    endtask

    task automatic test_defaults;
        logic b;
        rd(32'h0, 32'hbc030700);
        rd(32'h4, 32'h00000000);
        rd(32'h8, 32'hb02e2400);
        rd(32'hc, 32'h002e3205);
        chk(audio_pll_n, 32'h2e);
        chk(audio_pll_pre_divisor_field, 32'h24);
        @(negedge hclk);
        b = bus_clk;
        chk(bus_clk_n, !b);
        chk(clk_flp, b);
        @(negedge hclk);
        chk(bus_clk, !b);
        @(posedge hclk);
    endtask

    task automatic test_readback;
        logic [31:0] a [4] = '{32'h0, 32'h4, 32'h8, 32'hc};
        logic [31:0] m [4] = '{32'hffffff0f, 32'h03000000, 32'hf3ffff00, 32'h00ffff0f};
        for (int i = 0; i < 4; i++) wr(a[i], 32'hffffffff);
        for (int i = 0; i < 4; i++) rd(a[i], m[i]);
        for (int i = 0; i < 4; i++) wr(a[i], 32'h5a5a5a5a);
        for (int i = 0; i < 4; i++) rd(a[i], 32'h5a5a5a5a & m[i]);
    endtask

    task automatic test_refused;
        logic [31:0] r;
        wr(32'h4, 32'h0);
        bus(32'h4, 1'b1, 3'h0, 32'h01000000, r);
        rd(32'h4, 32'h0);
        wr(32'h10, 32'hffffffff);
        rd(32'h10, 32'h0);
        rd(32'h0, 32'h5a5a5a0a);
    endtask

    task automatic test_sources;
        logic [1:0] s;
        int n;
        int fast_exp [3] = '{12, 48, 24};
        int slow_exp [4] = '{6, 24, 16, 12};
        for (int i = 0; i < 3; i++) begin
            s = 2'(i);
            wr(32'h0, {4'hb, s, 2'h0, 24'h030703});
            repeat (24) @(posedge hclk);
            count_ticks(1'b0, 48, n);
            chk(32'(n), 32'(fast_exp[i]));
        end
        wr(32'h0, 32'hb0030703);
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            wr(32'h4, {6'h0, s, 24'h0});
            repeat (24) @(posedge hclk);
            count_ticks(1'b1, 48, n);
            chk(32'(n), 32'(slow_exp[i]));
        end
    endtask

    task automatic test_pin_dir;
        int n;
        wr(32'h0, 32'hbe070700);
        repeat (3) @(posedge hclk);
        chk(clk_io_oe, 32'h1);
        wr(32'h0, 32'hbc070700);
        repeat (24) @(posedge hclk);
        chk(clk_io_oe, 32'h0);
        count_ticks(1'b0, 48, n);
        chk(32'(n != 0), 32'h1);
    endtask

    task automatic test_audio;
        int n;
        wr(32'h8, 32'hb02e2400);
        wr(32'hc, 32'h00113205);
        rate_req <= 1'b1;
        n = 0;
        while (audio_pll_pre_divisor_field !== 8'h32 && n < 60) begin
            @(posedge hclk);
            n++;
        end
        chk(audio_pll_n, 32'h11);
        chk(audio_pll_pre_divisor_field, 32'h32);
        rate_req <= 1'b0;
        n = 0;
        while (audio_pll_pre_divisor_field !== 8'h24 && n < 60) begin
            @(posedge hclk);
            n++;
        end
        chk(audio_pll_n, 32'h2e);
        chk(audio_pll_pre_divisor_field, 32'h24);
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rate_req = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_defaults();
        test_readback();
        test_refused();
        test_sources();
        test_pin_dir();
        test_audio();
        print_verdict();
    end

    // Whole run is near seven hundred cycles; reaching twenty thousand cycles means a hang
    initial begin
        #400000;
        fail_count++;
        print_verdict();
    end
endmodule // io_clock_gen_pll_control_tb
